/* rtl/sms_sequencer.sv */
// start-up mode sequencer: power-on, config load, mode pick, boot, active
`timescale 1ns/1ps
`default_nettype none
module sms_sequencer (
   // clock and power-on reset
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   // mode pins, active low
   input  wire logic                 ext_rst_pin_low,
   input  wire logic                 prog_mode_select_pin,
   // boot configuration page read port
   output logic [10:0]               cfg_addr,
   output logic                      cfg_rd,
   input  wire logic [7:0]           cfg_data,
   // applied hardware configuration
   output logic [31:0]               io_dir,
   output logic                      cfg_loaded,
   // software board support parameters
   output logic                      bsp_wr,
   output logic [10:0]               bsp_addr,
   output logic [7:0]                bsp_data,
   // mode outputs
   output logic                      flash_emul_en,
   output logic                      low_power,
   output logic                      cpu_run,
   output logic                      osc_en,
   // peripheral gating
   input  wire logic                 cpu_idle,
   input  wire logic [7:0]           periph_req,
   output logic [7:0]                periph_en
);
   sms_pin_if pins ();
   sms_pkg::sms_state_t state;
   sms_pkg::sms_state_t next_state;
   logic [10:0] rd_addr;
   logic        rd_valid;
   logic [10:0] rd_addr_q;
   logic [11:0] boot_cnt;
   logic        load_done;

   sms_pin_sync u_sync (
      .ref_clk             (ref_clk),
      .reset               (reset),
      .ext_rst_pin_low     (ext_rst_pin_low),
      .prog_mode_select_pin(prog_mode_select_pin),
      .pins                (pins)
   );

   // the top byte is taken while its address stands, so load ends on that same edge
   assign load_done = rd_valid && (rd_addr_q == sms_pkg::PAGE_LAST);

   always_comb begin
      next_state = state;
      case (state)
         sms_pkg::SMS_POR: begin
            next_state = sms_pkg::SMS_LOAD;
         end
         sms_pkg::SMS_LOAD: begin
            if (load_done) begin
               next_state = sms_pkg::SMS_CHECK;
            end
         end
         sms_pkg::SMS_CHECK: begin
            // emulation takes priority over the hold when both pins are low
            if (pins.rst_low && pins.prog_low) begin
               next_state = sms_pkg::SMS_EMUL;
            end else if (pins.rst_low) begin
               next_state = sms_pkg::SMS_LOWPWR;
            end else begin
               next_state = sms_pkg::SMS_BOOT;
            end
         end
         sms_pkg::SMS_EMUL: begin
            // emulation lasts until reset is released, then a fresh start-up runs
            if (!pins.rst_low) begin
               next_state = sms_pkg::SMS_POR;
            end
         end
         sms_pkg::SMS_LOWPWR: begin
            if (!pins.rst_low) begin
               next_state = sms_pkg::SMS_BOOT;
            end
         end
         sms_pkg::SMS_BOOT: begin
            if (boot_cnt == 12'(sms_pkg::BOOT_CYC - 1)) begin
               next_state = sms_pkg::SMS_ACTIVE;
            end
         end
         sms_pkg::SMS_ACTIVE: begin
            next_state = sms_pkg::SMS_ACTIVE;
         end
         default: begin
            next_state = sms_pkg::SMS_POR;
         end
      endcase
      // a reset pin fall restarts from any state after the mode check
      if (pins.rst_fall && state != sms_pkg::SMS_LOAD && state != sms_pkg::SMS_POR
          && state != sms_pkg::SMS_CHECK) begin
         next_state = sms_pkg::SMS_LOAD;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state <= sms_pkg::SMS_POR;
      end else begin
         state <= next_state;
      end
   end

   // page reader: address out, data back one cycle later
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rd_addr   <= sms_pkg::ADDR_ZERO;
         rd_valid  <= 1'b0;
         rd_addr_q <= sms_pkg::ADDR_ZERO;
      end else begin
         rd_valid  <= (state == sms_pkg::SMS_LOAD) && !load_done;
         rd_addr_q <= rd_addr;
         // pointer parks on the top byte until the state leaves load
         if (state != sms_pkg::SMS_LOAD || load_done) begin
            rd_addr <= sms_pkg::ADDR_ZERO;
         end else if (rd_addr != sms_pkg::PAGE_LAST) begin
            rd_addr <= rd_addr + 11'h001;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cfg_addr <= sms_pkg::ADDR_ZERO;
         cfg_rd   <= 1'b0;
      end else begin
         cfg_addr <= rd_addr;
         cfg_rd   <= (state == sms_pkg::SMS_LOAD) && !load_done;
      end
   end

   // first structure: I/O direction, applied straight away to stop floating inputs
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         io_dir <= sms_pkg::IO_DIR_RESET;
      end else if (rd_valid && rd_addr_q < 11'(sms_pkg::IO_W / 8)) begin
         io_dir[rd_addr_q[1:0]*8 +: 8] <= cfg_data;
      end
   end

   // drops at the start of every reload so nothing trusts a half-read page
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cfg_loaded <= 1'b0;
      end else if (state == sms_pkg::SMS_LOAD && !rd_valid) begin
         cfg_loaded <= 1'b0;
      end else if (load_done) begin
         cfg_loaded <= 1'b1;
      end
   end

   // second structure: board support bytes streamed to software storage
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         bsp_wr   <= 1'b0;
         bsp_addr <= sms_pkg::ADDR_ZERO;
         bsp_data <= 8'h00;
      end else begin
         bsp_wr   <= rd_valid && (rd_addr_q > sms_pkg::HW_CFG_LAST);
         bsp_addr <= rd_addr_q;
         bsp_data <= cfg_data;
      end
   end

   // cleared outside boot so every entry runs the full boot time
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         boot_cnt <= 12'h000;
      end else if (state == sms_pkg::SMS_BOOT) begin
         boot_cnt <= boot_cnt + 12'h001;
      end else begin
         boot_cnt <= 12'h000;
      end
   end

   // emulation and hold are separate states, so at most one of these is up
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         flash_emul_en <= 1'b0;
         low_power     <= 1'b0;
      end else begin
         flash_emul_en <= (next_state == sms_pkg::SMS_EMUL);
         low_power     <= (next_state == sms_pkg::SMS_LOWPWR);
      end
   end

   // oscillator gated only in the low-energy hold; boot and active need it running
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         osc_en <= 1'b1;
      end else begin
         osc_en <= (next_state != sms_pkg::SMS_LOWPWR);
      end
   end

   // idle is the second operational state, not a trip back through start-up
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cpu_run <= 1'b0;
      end else begin
         cpu_run <= (next_state == sms_pkg::SMS_ACTIVE) && !cpu_idle;
      end
   end

   // each peripheral follows its own request, and only while active
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         periph_en <= sms_pkg::PERIPH_NONE;
      end else if (next_state == sms_pkg::SMS_ACTIVE) begin
         periph_en <= periph_req;
      end else begin
         periph_en <= sms_pkg::PERIPH_NONE;
      end
   end
endmodule
`default_nettype wire

/* rtl/sms_pkg.sv */
// constants and types for the start-up mode sequencer
package sms_pkg;
   localparam int          PAGE_BYTES      = 2048;
   localparam int          ADDR_W          = 11;
   localparam int          HW_CFG_BYTES    = 16;
   localparam int          IO_W            = 32;
   localparam int          PERIPH_W        = 8;
   localparam int          BOOT_NS         = 1000;
   localparam int          CLK_NS          = 25;
   localparam int          BOOT_CYC        = (BOOT_NS + CLK_NS - 1) / CLK_NS;
   localparam int          CNT_W           = 12;
   localparam logic [10:0] ADDR_ZERO       = 11'h000;
   localparam logic [10:0] HW_CFG_LAST     = 11'h00F;
   localparam logic [10:0] PAGE_LAST       = 11'h7FF;
   localparam logic [31:0] IO_DIR_RESET    = 32'h00000000;
   localparam logic [7:0]  PERIPH_NONE     = 8'h00;
   localparam logic [1:0]  SYNC_IDLE       = 2'h3;

   typedef enum logic [6:0] {
      SMS_POR      = 7'h01,
      SMS_LOAD     = 7'h02,
      SMS_CHECK    = 7'h04,
      SMS_EMUL     = 7'h08,
      SMS_LOWPWR   = 7'h10,
      SMS_BOOT     = 7'h20,
      SMS_ACTIVE   = 7'h40
   } sms_state_t;
endpackage

/* rtl/sms_pin_if.sv */
// synchronised pin levels shared between the sequencer and its synchroniser
`timescale 1ns/1ps
`default_nettype none
interface sms_pin_if;
   logic rst_low;
   logic prog_low;
   logic rst_fall;
   modport src (output rst_low, output prog_low, output rst_fall);
   modport dst (input rst_low, input prog_low, input rst_fall);
endinterface
`default_nettype wire

/* rtl/sms_pin_sync.sv */
// two-flop synchronisers for the mode pins with reset falling-edge detect
`timescale 1ns/1ps
`default_nettype none
module sms_pin_sync (
   // clock and reset
   input  wire logic  ref_clk,
   input  wire logic  reset,
   // raw pins
   input  wire logic  ext_rst_pin_low,
   input  wire logic  prog_mode_select_pin,
   // synchronised levels
   sms_pin_if.src     pins
);
   logic [1:0] rst_meta;
   logic [1:0] prog_meta;
   logic       rst_seen;

   // pins idle high; first stage feeds only the second
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rst_meta  <= sms_pkg::SYNC_IDLE;
         prog_meta <= sms_pkg::SYNC_IDLE;
      end else begin
         rst_meta  <= {rst_meta[0], ext_rst_pin_low};
         prog_meta <= {prog_meta[0], prog_mode_select_pin};
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rst_seen <= 1'b1;
      end else begin
         rst_seen <= rst_meta[1];
      end
   end

   assign pins.rst_low  = ~rst_meta[1];
   assign pins.prog_low = ~prog_meta[1];
   assign pins.rst_fall = rst_seen & ~rst_meta[1];
endmodule
`default_nettype wire

/* bench/sms_sequencer_properties.sv */
// port assertions for the start-up mode sequencer
`timescale 1ns/1ps
`default_nettype none
module sms_seq_props (
   // clock and reset
   input wire logic        ref_clk,
   input wire logic        reset,
   // page read and board support
   input wire logic [10:0] cfg_addr,
   input wire logic        cfg_rd,
   input wire logic        bsp_wr,
   input wire logic [10:0] bsp_addr,
   // modes and gating
   input wire logic        flash_emul_en,
   input wire logic        low_power,
   input wire logic        cpu_run,
   input wire logic        osc_en,
   input wire logic        cpu_idle,
   input wire logic [7:0]  periph_req,
   input wire logic [7:0]  periph_en
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_LOAD_FROM_ZERO: assert property ($rose(cfg_rd) |-> cfg_addr == 11'h000)
      else $error("page read did not start at byte zero");
   AST_LOAD_ASCENDS: assert property (cfg_rd && $past(cfg_rd) |-> cfg_addr == $past(cfg_addr) + 11'h001)
      else $error("page address skipped or repeated");
   AST_LOAD_ENDS_AT_TOP: assert property ($fell(cfg_rd) |-> $past(cfg_addr) == 11'h7FF)
      else $error("page read ended before the last byte");
   AST_BSP_ABOVE_HW: assert property (bsp_wr |-> bsp_addr >= 11'h010)
      else $error("board support write inside hardware structure");
   AST_LOAD_QUIET_MODES: assert property (cfg_rd && $past(cfg_rd) |-> !(flash_emul_en || low_power || cpu_run))
      else $error("mode output up during page load");
   AST_EMUL_SUSPENDS: assert property (flash_emul_en |-> !cpu_run && !low_power && periph_en == 8'h00)
      else $error("normal operation during flash emulation");
   AST_OSC_OFF_ONLY_IN_HOLD: assert property (osc_en == !low_power)
      else $error("oscillator state does not match hold");
   AST_RUN_NEEDS_BUSY_CPU: assert property (cpu_run |-> !$past(cpu_idle))
      else $error("processor running while idle");
   AST_PERIPH_ON_REQUEST: assert property ((periph_en & ~$past(periph_req)) == 8'h00)
      else $error("peripheral enabled without request");
   AST_BOOT_BEFORE_RUN: assert property ($fell(low_power) |-> !cpu_run [*8])
      else $error("active state without boot sequence");
   cover property (flash_emul_en);
   cover property ($fell(low_power));
   cover property ($rose(cpu_run));
endmodule
`default_nettype wire

/* bench/sms_flash_model.sv */
// boot configuration page model answering one byte per address
`timescale 1ns/1ps
`default_nettype none
module sms_flash_model (
   // page read port
   input wire logic        cfg_rd,
   input wire logic [10:0] cfg_addr,
   output logic [7:0]      cfg_data
);
   // the sequencer takes each byte in the cycle its address stands, so the read is direct
   // outside a read the port shows the inverse, so a stray sample never matches
   assign cfg_data = cfg_rd ? (cfg_addr[7:0] ^ 8'hA5) : ~(cfg_addr[7:0] ^ 8'hA5);
endmodule
`default_nettype wire

/* bench/startup_mode_sequencer_tb_top.sv */
// self-checking bench for the start-up mode sequencer
`timescale 1ns/1ps
`default_nettype none
module startup_mode_sequencer_tb_top;
   logic        ref_clk, reset, ext_rst_pin_low, prog_mode_select_pin, cpu_idle;
   logic [10:0] cfg_addr, bsp_addr;
   logic [7:0]  cfg_data, bsp_data, periph_req, periph_en;
   logic [31:0] io_dir;
   logic        cfg_rd, cfg_loaded, bsp_wr, flash_emul_en, low_power, cpu_run, osc_en;
   int          failures, checks_done, bsp_cnt, bsp_bad, wait_n, cyc;
   sms_sequencer i_dut (.ref_clk(ref_clk), .reset(reset), .ext_rst_pin_low(ext_rst_pin_low),
      .prog_mode_select_pin(prog_mode_select_pin), .cfg_addr(cfg_addr), .cfg_rd(cfg_rd),
      .cfg_data(cfg_data), .io_dir(io_dir), .cfg_loaded(cfg_loaded), .bsp_wr(bsp_wr),
      .bsp_addr(bsp_addr), .bsp_data(bsp_data), .flash_emul_en(flash_emul_en),
      .low_power(low_power), .cpu_run(cpu_run), .osc_en(osc_en), .cpu_idle(cpu_idle),
      .periph_req(periph_req), .periph_en(periph_en));
   sms_flash_model i_flash (.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_data(cfg_data));
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (bsp_wr === 1'b1) bsp_cnt++;
      if (bsp_wr === 1'b1 && bsp_data !== (bsp_addr[7:0] ^ 8'hA5)) bsp_bad++;
      cyc++;
      if (cyc == 40000) begin
         failures++;
         print_verdict();
      end
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function logic flag(input int s);
      flag = (s == 0) ? flash_emul_en : (s == 1) ? low_power : cpu_run;
   endfunction
   task wait_flag(input int s);
      wait_n = 0;
      while (flag(s) !== 1'b1 && wait_n < 3000) begin
         @(posedge ref_clk);
         wait_n++;
      end
      #1;
   endtask
   // pins are active low, driven as an outside programmer would
   task set_pins(input logic r, input logic p);
      @(posedge ref_clk);
      ext_rst_pin_low <= r;
      prog_mode_select_pin <= p;
   endtask
   task test_normal;
      wait_flag(2);
      check(cpu_run, 32'h1);
      check(io_dir, 32'hA6A7A4A5);
      check(bsp_cnt, 32'd2032);
      check(bsp_bad, 32'h0);
      check(cfg_loaded, 32'h1);
      check(osc_en, 32'h1);
      check(flash_emul_en, 32'h0);
      check(periph_en, 32'h5A);
      @(posedge ref_clk);
      cpu_idle <= 1'b1;
      periph_req <= 8'h3C;
      repeat (2) @(posedge ref_clk);
      #1 check(cpu_run, 32'h0);
      check(periph_en, 32'h3C);
      @(posedge ref_clk);
      cpu_idle <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 check(cpu_run, 32'h1);
      $display("test_normal done");
   endtask
   task test_emul;
      bsp_cnt = 0;
      set_pins(1'b0, 1'b0);
      wait_flag(0);
      check(flash_emul_en, 32'h1);
      repeat (20) @(posedge ref_clk);
      #1 check(flash_emul_en, 32'h1);
      check(cpu_run, 32'h0);
      check(periph_en, 32'h0);
      set_pins(1'b1, 1'b1);
      wait_flag(2);
      check(cpu_run, 32'h1);
      check(bsp_cnt, 32'd4064);
      check(bsp_bad, 32'h0);
      $display("test_emul done");
   endtask
   task test_lowpower;
      set_pins(1'b0, 1'b1);
      wait_flag(1);
      check(low_power, 32'h1);
      check(osc_en, 32'h0);
      repeat (30) @(posedge ref_clk);
      #1 check(low_power, 32'h1);
      set_pins(1'b1, 1'b1);
      wait_flag(2);
      check(cpu_run, 32'h1);
      // two sync edges, one decision edge, the boot itself, one edge to see the output
      check(wait_n, sms_pkg::BOOT_CYC + 4);
      $display("test_lowpower done");
   endtask
   task test_por;
      @(posedge ref_clk);
      reset <= 1'b1;
      prog_mode_select_pin <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 check(cpu_run, 32'h0);
      check(osc_en, 32'h1);
      check(cfg_loaded, 32'h0);
      check(io_dir, sms_pkg::IO_DIR_RESET);
      @(posedge ref_clk);
      reset <= 1'b0;
      wait_flag(2);
      check(cpu_run, 32'h1);
      check(flash_emul_en, 32'h0);
      check(cfg_loaded, 32'h1);
      $display("test_por done");
   endtask
   task print_verdict;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      reset = 1'b1;
      ext_rst_pin_low = 1'b1;
      prog_mode_select_pin = 1'b1;
      cpu_idle = 1'b0;
      periph_req = 8'h5A;
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      test_normal();
      test_emul();
      test_lowpower();
      test_por();
      print_verdict();
   end
endmodule
bind sms_sequencer sms_seq_props i_props (.ref_clk(ref_clk), .reset(reset),
   .cfg_addr(cfg_addr), .cfg_rd(cfg_rd), .bsp_wr(bsp_wr), .bsp_addr(bsp_addr),
   .flash_emul_en(flash_emul_en), .low_power(low_power), .cpu_run(cpu_run), .osc_en(osc_en),
   .cpu_idle(cpu_idle), .periph_req(periph_req), .periph_en(periph_en));
`default_nettype wire
